/* File: design/timer_defines.svh */
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// Register page and addresses
`define TMR_PAGE 8'h00
`define ADDR_CONTROL 8'hc8
`define ADDR_RELOAD_LOW 8'hca
`define ADDR_RELOAD_HIGH 8'hcb
`define ADDR_COUNT_LOW 8'hcc
`define ADDR_COUNT_HIGH 8'hcd

// Control register field positions
`define BIT_HIGH_FLAG 7
`define BIT_LOW_FLAG 6
`define BIT_LOW_IRQ_EN 5
`define BIT_CAPTURE_EN 4
`define BIT_SPLIT 3
`define BIT_RUN 2
`define BIT_UNUSED 1
`define BIT_EXT_CLK 0

// Reset values
`define CONTROL_RESET 8'h00
`define BYTE_RESET 8'h00

// Prescaler divide ratios
`define SYSCLK_DIV 12
`define EXTCLK_DIV 8

`endif

/* File: design/timer_pkg.sv */
package timer_pkg;
	typedef logic [7:0] byte_t;
	typedef enum logic {MODE_WIDE, MODE_SPLIT} count_mode_e;
endpackage : timer_pkg

/* File: design/tick_divider.sv */
`timescale 1ns/1ps
`default_nettype none
// Emits one-cycle tick every DIV enabled cycles
module tick_divider #(
	parameter int unsigned DIV = 12,
	parameter int unsigned W = 4
) (
	input wire logic core_clk, // System clock
	input wire logic arst_n, // Async reset, active low
	input wire logic en, // Count this cycle
	output logic tick // One-cycle pulse on wrap
);
	logic [W-1:0] phase;

	// Phase counter; tick registered so consumers see a clean pulse
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			phase <= '0;
			tick <= 1'b0;
		end else if (en) begin
			if (phase == W'(DIV - 1)) begin
				phase <= '0;
				tick <= 1'b1;
			end else begin
				phase <= phase + W'(1);
				tick <= 1'b0;
			end
		end else begin
			tick <= 1'b0;
		end
	end
endmodule : tick_divider
`default_nettype wire

/* File: design/byte_counter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.svh"
// One 8-bit up counter with reload and software write
module byte_counter
	import timer_pkg::*;
(
	input wire logic core_clk, // System clock
	input wire logic arst_n, // Async reset, active low
	input wire logic inc, // Increment this cycle
	input wire logic load, // Take reload value
	input wire byte_t reload_val, // Reload value
	input wire logic wr_en, // Software write
	input wire byte_t wr_data, // Software data
	output byte_t count, // Current count
	output logic wrap // Rolls from ff this cycle
);
	assign wrap = inc && (count == 8'hff);

	// Software write wins over counting so a written value is never lost
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			count <= `BYTE_RESET;
		end else if (wr_en) begin
			count <= wr_data;
		end else if (load) begin
			count <= reload_val;
		end else if (inc) begin
			count <= count + 8'h01;
		end
	end
endmodule : byte_counter
`default_nettype wire

/* File: design/timer_ctrl.sv */
// Behaviour
// - High flag sets on high byte rollover
// - Enabled interrupt follows high flag
// - Low flag sets on low byte rollover
// - Hardware never clears either flag
// - Low enable adds low overflow interrupts
// - Capture only while capture enable set
// - Split bit picks one 16 or two 8
// - Run bit gates counting in wide mode
// - Split mode: run gates high byte only
// - Bit one reads zero, ignores writes
// - Ext select, capture off: sysclk/12 or ext/8
// - Ext select applies to both bytes
// - Control at 0xc8 page 0, bit-addressable
// - Capture copies count, sets high flag
// - Wide wrap loads reload into counter
// - Byte clock select forces system clock
// - Interrupt only while enable bit set
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.svh"
module timer_ctrl
	import timer_pkg::*;
(
	input wire logic core_clk, // System clock, 10 MHz
	input wire logic arst_n, // Async reset, active low
	input wire logic [7:0] sfr_addr, // Register address
	input wire logic [7:0] sfr_page, // Register page
	input wire logic sfr_wr, // Byte write strobe
	input wire byte_t sfr_wdata, // Byte write data
	input wire logic sfr_rd, // Read strobe
	output byte_t sfr_rdata, // Read data, one cycle later
	input wire logic sfr_bit_wr, // Single-bit write strobe
	input wire logic [2:0] sfr_bit_idx, // Bit number
	input wire logic sfr_bit_val, // Bit value
	input wire logic high_byte_clock_select, // From clock control register
	input wire logic low_byte_clock_select, // From clock control register
	input wire logic timer_irq_enable, // Interrupt enable bit 5
	input wire logic ext_osc, // External oscillator level
	output logic timer_irq // Interrupt request, level
);
	byte_t timer_control_reg;
	byte_t next_ctrl;
	byte_t sw_ctrl;
	byte_t reload_low_byte;
	byte_t reload_high_byte;
	byte_t count_low_byte;
	byte_t count_high_byte;
	count_mode_e mode;
	logic page_hit;
	logic wr_ctrl;
	logic bit_wr_ctrl;
	logic wr_rl_low;
	logic wr_rl_high;
	logic wr_cnt_low;
	logic wr_cnt_high;
	logic ext_q;
	logic ext_prev;
	logic ext_edge;
	logic sys12_tick;
	logic ext8_tick;
	logic slow_tick;
	logic low_tick;
	logic high_tick;
	logic low_inc;
	logic high_inc;
	logic low_wrap;
	logic high_wrap;
	logic full_wrap;
	logic low_load;
	logic high_load;
	logic capture_evt;
	logic high_set;
	logic low_set;
	logic sw_clr_high;
	logic sw_clr_low;

	// Register decode on page zero only
	assign page_hit = (sfr_page == `TMR_PAGE);
	assign wr_ctrl = sfr_wr && page_hit && (sfr_addr == `ADDR_CONTROL);
	assign bit_wr_ctrl = sfr_bit_wr && page_hit && (sfr_addr == `ADDR_CONTROL);
	assign wr_rl_low = sfr_wr && page_hit && (sfr_addr == `ADDR_RELOAD_LOW);
	assign wr_rl_high = sfr_wr && page_hit && (sfr_addr == `ADDR_RELOAD_HIGH);
	assign wr_cnt_low = sfr_wr && page_hit && (sfr_addr == `ADDR_COUNT_LOW);
	assign wr_cnt_high = sfr_wr && page_hit && (sfr_addr == `ADDR_COUNT_HIGH);

	// Mode from split bit
	assign mode = timer_control_reg[`BIT_SPLIT] ? MODE_SPLIT : MODE_WIDE;

	// External oscillator edge; input already synchronous to core_clk
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ext_q <= 1'b0;
			ext_prev <= 1'b0;
		end else begin
			ext_q <= ext_osc;
			ext_prev <= ext_q;
		end
	end
	assign ext_edge = ext_q && !ext_prev;

	// System clock divided by 12
	tick_divider #(
		.DIV(`SYSCLK_DIV),
		.W(4)
	) u_sys12 (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.en(1'b1),
		.tick(sys12_tick)
	);

	// External clock divided by 8; tick marks the falling edge of the divided clock
	tick_divider #(
		.DIV(`EXTCLK_DIV),
		.W(3)
	) u_ext8 (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.en(ext_edge),
		.tick(ext8_tick)
	);

	// Capture measures the external clock, so it cannot also be the timebase
	assign slow_tick = (timer_control_reg[`BIT_EXT_CLK] && !timer_control_reg[`BIT_CAPTURE_EN])
		? ext8_tick : sys12_tick;
	assign low_tick = low_byte_clock_select ? 1'b1 : slow_tick;
	assign high_tick = high_byte_clock_select ? 1'b1 : slow_tick;

	// Increment enables; wide mode chains high off low rollover
	always_comb begin
		if (mode == MODE_SPLIT) begin
			low_inc = low_tick;
			high_inc = high_tick && timer_control_reg[`BIT_RUN];
		end else begin
			low_inc = low_tick && timer_control_reg[`BIT_RUN];
			high_inc = low_wrap;
		end
	end

	// Reload selection
	assign full_wrap = (mode == MODE_WIDE) && high_wrap;
	assign low_load = (mode == MODE_SPLIT) ? low_wrap : full_wrap;
	assign high_load = high_wrap;

	byte_counter u_low (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.inc(low_inc),
		.load(low_load),
		.reload_val(reload_low_byte),
		.wr_en(wr_cnt_low),
		.wr_data(sfr_wdata),
		.count(count_low_byte),
		.wrap(low_wrap)
	);

	byte_counter u_high (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.inc(high_inc),
		.load(high_load),
		.reload_val(reload_high_byte),
		.wr_en(wr_cnt_high),
		.wr_data(sfr_wdata),
		.count(count_high_byte),
		.wrap(high_wrap)
	);

	// Capture event only with capture enabled
	assign capture_evt = timer_control_reg[`BIT_CAPTURE_EN] && ext8_tick;

	// Reload registers; a capture beats a same-cycle software write
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			reload_low_byte <= `BYTE_RESET;
			reload_high_byte <= `BYTE_RESET;
		end else if (capture_evt) begin
			reload_low_byte <= count_low_byte;
			reload_high_byte <= count_high_byte;
		end else begin
			if (wr_rl_low) begin
				reload_low_byte <= sfr_wdata;
			end
			if (wr_rl_high) begin
				reload_high_byte <= sfr_wdata;
			end
		end
	end

	// Flag set sources
	assign high_set = high_wrap || capture_evt;
	assign low_set = low_wrap;

	// Software view of the control byte after byte or bit write
	always_comb begin
		sw_ctrl = timer_control_reg;
		if (wr_ctrl) begin
			sw_ctrl = sfr_wdata;
		end
		if (bit_wr_ctrl) begin
			sw_ctrl[sfr_bit_idx] = sfr_bit_val;
		end
	end
	assign sw_clr_high = timer_control_reg[`BIT_HIGH_FLAG] && !sw_ctrl[`BIT_HIGH_FLAG];
	assign sw_clr_low = timer_control_reg[`BIT_LOW_FLAG] && !sw_ctrl[`BIT_LOW_FLAG];

	// Hardware only ever sets flags, and its set overrides a clear
	always_comb begin
		next_ctrl = sw_ctrl;
		next_ctrl[`BIT_HIGH_FLAG] = sw_ctrl[`BIT_HIGH_FLAG] || high_set;
		next_ctrl[`BIT_LOW_FLAG] = sw_ctrl[`BIT_LOW_FLAG] || low_set;
		next_ctrl[`BIT_UNUSED] = 1'b0;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			timer_control_reg <= `CONTROL_RESET;
		end else begin
			timer_control_reg <= next_ctrl;
		end
	end

	// Interrupt level from flags; registered so the output is glitch free
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			timer_irq <= 1'b0;
		end else begin
			timer_irq <= timer_irq_enable
				&& (timer_control_reg[`BIT_HIGH_FLAG]
				|| (timer_control_reg[`BIT_LOW_IRQ_EN]
				&& timer_control_reg[`BIT_LOW_FLAG]));
		end
	end

	// Read data; unmapped addresses and other pages read zero
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd) begin
			if (!page_hit) begin
				sfr_rdata <= 8'h00;
			end else begin
				case (sfr_addr)
					`ADDR_CONTROL: sfr_rdata <= timer_control_reg;
					`ADDR_RELOAD_LOW: sfr_rdata <= reload_low_byte;
					`ADDR_RELOAD_HIGH: sfr_rdata <= reload_high_byte;
					`ADDR_COUNT_LOW: sfr_rdata <= count_low_byte;
					`ADDR_COUNT_HIGH: sfr_rdata <= count_high_byte;
					default: sfr_rdata <= 8'h00;
				endcase
			end
		end
	end

	// Checks
	chk_high_flag_set: assert property (@(posedge core_clk) disable iff (!arst_n)
		high_wrap |=> timer_control_reg[`BIT_HIGH_FLAG])
		else $error("high overflow did not set high flag");

	chk_irq_high_flag: assert property (@(posedge core_clk) disable iff (!arst_n)
		(timer_control_reg[`BIT_HIGH_FLAG] && timer_irq_enable) |=> timer_irq)
		else $error("high flag with enable gave no interrupt");

	chk_low_flag_set: assert property (@(posedge core_clk) disable iff (!arst_n)
		low_wrap |=> timer_control_reg[`BIT_LOW_FLAG])
		else $error("low overflow did not set low flag");

	chk_flags_sticky: assert property (@(posedge core_clk) disable iff (!arst_n)
		(timer_control_reg[`BIT_HIGH_FLAG] && !sw_clr_high)
		|=> timer_control_reg[`BIT_HIGH_FLAG])
		else $error("high flag dropped without software clear");

	chk_low_irq_path: assert property (@(posedge core_clk) disable iff (!arst_n)
		(timer_control_reg[`BIT_LOW_FLAG] && timer_control_reg[`BIT_LOW_IRQ_EN]
		&& timer_irq_enable) |=> timer_irq)
		else $error("low flag with low enable gave no interrupt");

	chk_capture_gate: assert property (@(posedge core_clk) disable iff (!arst_n)
		(!timer_control_reg[`BIT_CAPTURE_EN] && !wr_rl_low && !wr_rl_high)
		|=> $stable(reload_low_byte) && $stable(reload_high_byte))
		else $error("reload changed with capture disabled");

	chk_split_reload: assert property (@(posedge core_clk) disable iff (!arst_n)
		(mode == MODE_SPLIT && low_wrap && !wr_cnt_low)
		|=> count_low_byte == $past(reload_low_byte))
		else $error("split low byte did not reload");

	chk_run_halts: assert property (@(posedge core_clk) disable iff (!arst_n)
		(mode == MODE_WIDE && !timer_control_reg[`BIT_RUN] && !wr_cnt_low && !wr_cnt_high)
		|=> $stable(count_low_byte) && $stable(count_high_byte))
		else $error("wide counter moved while stopped");

	chk_split_low_free: assert property (@(posedge core_clk) disable iff (!arst_n)
		(mode == MODE_SPLIT && low_byte_clock_select && !wr_cnt_low && !low_wrap)
		|=> count_low_byte == $past(count_low_byte) + 8'h01)
		else $error("split low byte did not run freely");

	chk_unused_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
		wr_ctrl |=> timer_control_reg[`BIT_UNUSED] == 1'b0)
		else $error("unused control bit not zero");

	chk_capture_copy: assert property (@(posedge core_clk) disable iff (!arst_n)
		capture_evt |=> (reload_low_byte == $past(count_low_byte))
		&& (reload_high_byte == $past(count_high_byte))
		&& timer_control_reg[`BIT_HIGH_FLAG])
		else $error("capture did not copy count");

	chk_wide_reload: assert property (@(posedge core_clk) disable iff (!arst_n)
		(full_wrap && !wr_cnt_low && !wr_cnt_high)
		|=> {count_high_byte, count_low_byte} == {$past(reload_high_byte), $past(reload_low_byte)})
		else $error("wide wrap did not load reload value");

	chk_irq_needs_en: assert property (@(posedge core_clk) disable iff (!arst_n)
		!timer_irq_enable |=> !timer_irq)
		else $error("interrupt raised while disabled");

	chk_set_wins: assert property (@(posedge core_clk) disable iff (!arst_n)
		(sw_clr_low && low_set) |=> timer_control_reg[`BIT_LOW_FLAG])
		else $error("software clear beat hardware set");

endmodule : timer_ctrl
`default_nettype wire

/* File: tb/test_timer2_control_and_capture.sv */
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.svh"
module test_timer2_control_and_capture
	import timer_pkg::*;
;
	logic core_clk, arst_n, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val;
	logic [7:0] sfr_addr, sfr_page;
	logic [2:0] sfr_bit_idx;
	byte_t sfr_wdata, sfr_rdata, d, h1;
	logic high_byte_clock_select, low_byte_clock_select, timer_irq_enable, ext_osc, timer_irq;
	int error_cnt = 0;
	int n_checks = 0;

	timer_ctrl u_dut (.core_clk(core_clk), .arst_n(arst_n), .sfr_addr(sfr_addr),
		.sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
		.sfr_rdata(sfr_rdata), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_idx(sfr_bit_idx),
		.sfr_bit_val(sfr_bit_val), .high_byte_clock_select(high_byte_clock_select),
		.low_byte_clock_select(low_byte_clock_select), .timer_irq_enable(timer_irq_enable),
		.ext_osc(ext_osc), .timer_irq(timer_irq));

	// 10 MHz system clock
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check

	// One-cycle strobes, launched just after an edge
	task automatic wr(input logic [7:0] a, input byte_t v);
		@(posedge core_clk);
		sfr_addr <= a;
		sfr_wdata <= v;
		sfr_wr <= 1'b1;
		@(posedge core_clk);
		sfr_wr <= 1'b0;
	endtask : wr

	task automatic bwr(input logic [2:0] i, input logic v);
		@(posedge core_clk);
		sfr_addr <= `ADDR_CONTROL;
		sfr_bit_idx <= i;
		sfr_bit_val <= v;
		sfr_bit_wr <= 1'b1;
		@(posedge core_clk);
		sfr_bit_wr <= 1'b0;
	endtask : bwr

	// Read data lands on the edge after the strobe
	task automatic rd(input logic [7:0] a, output byte_t v);
		@(posedge core_clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge core_clk);
		sfr_rd <= 1'b0;
		#1 v = sfr_rdata;
	endtask : rd

	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge core_clk);
			ext_osc <= 1'b1;
			repeat (2) @(posedge core_clk);
			ext_osc <= 1'b0;
			@(posedge core_clk);
		end
	endtask : pulses

	task automatic irq_after(input int n, input logic e, input string msg);
		repeat (n) @(posedge core_clk);
		#1 check({7'h00, timer_irq}, {7'h00, e}, msg);
	endtask : irq_after

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : stop_test

	// Whole sequence needs well under a thousand cycles
	initial begin
		#(5000 * 100);
		error_cnt++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		stop_test();
	end

	initial begin
		arst_n = 1'b0;
		{sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, ext_osc} = '0;
		sfr_addr = 8'h00;
		sfr_page = `TMR_PAGE;
		sfr_wdata = 8'h00;
		sfr_bit_idx = 3'h0;
		high_byte_clock_select = 1'b0;
		low_byte_clock_select = 1'b0;
		timer_irq_enable = 1'b1;
		repeat (10) @(posedge core_clk);
		arst_n <= 1'b1;

		// Reset values, unmapped address, foreign page, unused bit
		rd(`ADDR_CONTROL, d); check(d, 8'h00, "control reset");
		rd(`ADDR_RELOAD_HIGH, d); check(d, 8'h00, "reload reset");
		rd(8'hc9, d); check(d, 8'h00, "unmapped read");
		wr(`ADDR_CONTROL, 8'h02); rd(`ADDR_CONTROL, d); check(d, 8'h00, "unused bit");
		bwr(3'h2, 1'b1); bwr(3'h1, 1'b1);
		rd(`ADDR_CONTROL, d); check(d, 8'h04, "bit write");
		sfr_page <= 8'h01;
		rd(`ADDR_CONTROL, d); check(d, 8'h00, "foreign page");
		sfr_page <= `TMR_PAGE;
		wr(`ADDR_CONTROL, 8'h00);
		$display("test registers done");

		// Wide wrap from ffff reloads and sets both flags
		low_byte_clock_select <= 1'b1;
		wr(`ADDR_RELOAD_LOW, 8'h34); wr(`ADDR_RELOAD_HIGH, 8'h12);
		wr(`ADDR_COUNT_LOW, 8'hfe); wr(`ADDR_COUNT_HIGH, 8'hff);
		wr(`ADDR_CONTROL, 8'h04);
		for (int i = 0; i < 20 && timer_irq !== 1'b1; i++) @(posedge core_clk);
		check({7'h00, timer_irq}, 8'h01, "wide irq");
		bwr(3'h2, 1'b0);
		rd(`ADDR_COUNT_HIGH, d); check(d, 8'h12, "reload high");
		rd(`ADDR_CONTROL, d); check(d, 8'hc0, "wide flags");
		rd(`ADDR_COUNT_LOW, h1); repeat (20) @(posedge core_clk);
		rd(`ADDR_COUNT_LOW, d); check(d, h1, "halted");
		rd(`ADDR_CONTROL, d); check(d, 8'hc0, "flags sticky");
		timer_irq_enable <= 1'b0;
		irq_after(3, 1'b0, "irq masked");
		timer_irq_enable <= 1'b1;
		wr(`ADDR_CONTROL, 8'h00);
		irq_after(2, 1'b0, "flags cleared");
		$display("test wide done");

		// Split, run clear: low byte runs, high byte holds
		wr(`ADDR_COUNT_LOW, 8'hfe); wr(`ADDR_CONTROL, 8'h08);
		irq_after(10, 1'b0, "low irq off");
		rd(`ADDR_CONTROL, d); check(d, 8'h48, "low flag only");
		rd(`ADDR_COUNT_HIGH, h1); repeat (5) @(posedge core_clk);
		rd(`ADDR_COUNT_HIGH, d); check(d, h1, "high held");
		rd(`ADDR_COUNT_LOW, h1); repeat (5) @(posedge core_clk);
		rd(`ADDR_COUNT_LOW, d); check({7'h00, d != h1}, 8'h01, "low runs");
		bwr(3'h5, 1'b1);
		irq_after(2, 1'b1, "low irq on");
		// Low byte written to fe is at ff when the clearing control write lands
		wr(`ADDR_COUNT_LOW, 8'hfe); wr(`ADDR_CONTROL, 8'h08);
		rd(`ADDR_CONTROL, d); check(d, 8'h48, "set beats clear");
		wr(`ADDR_CONTROL, 8'h00);
		$display("test split done");

		// External clock divided by eight
		low_byte_clock_select <= 1'b0;
		wr(`ADDR_COUNT_LOW, 8'h00); wr(`ADDR_COUNT_HIGH, 8'h00);
		wr(`ADDR_CONTROL, 8'h05); pulses(16); repeat (4) @(posedge core_clk);
		bwr(3'h2, 1'b0);
		rd(`ADDR_COUNT_LOW, d); check(d, 8'h02, "ext div8");
		rd(`ADDR_CONTROL, d); check(d, 8'h01, "no capture");
		// Free-running divide-by-12 phase is unknown, so allow one tick either way
		wr(`ADDR_COUNT_LOW, 8'h00); wr(`ADDR_CONTROL, 8'h04);
		repeat (120) @(posedge core_clk); bwr(3'h2, 1'b0);
		rd(`ADDR_COUNT_LOW, d); check({7'h00, d >= 8'h09 && d <= 8'h0b}, 8'h01, "sys div12");
		// Split with ext select drives both bytes
		wr(`ADDR_COUNT_LOW, 8'h00); wr(`ADDR_COUNT_HIGH, 8'h00);
		wr(`ADDR_CONTROL, 8'h0d); pulses(8); repeat (4) @(posedge core_clk);
		rd(`ADDR_COUNT_LOW, d); check(d, 8'h01, "split ext low");
		rd(`ADDR_COUNT_HIGH, d); check(d, 8'h01, "split ext high");
		// High byte select forces the system clock
		high_byte_clock_select <= 1'b1;
		rd(`ADDR_COUNT_HIGH, h1); repeat (5) @(posedge core_clk);
		rd(`ADDR_COUNT_HIGH, d); check({7'h00, d != h1}, 8'h01, "high sysclk");
		high_byte_clock_select <= 1'b0;
		wr(`ADDR_CONTROL, 8'h00);
		$display("test clocks done");

		// Capture copies the running count into reload
		low_byte_clock_select <= 1'b1;
		wr(`ADDR_RELOAD_LOW, 8'h00); wr(`ADDR_RELOAD_HIGH, 8'h00);
		wr(`ADDR_COUNT_LOW, 8'h00); wr(`ADDR_COUNT_HIGH, 8'h00);
		wr(`ADDR_CONTROL, 8'h14); pulses(8); repeat (4) @(posedge core_clk);
		bwr(3'h2, 1'b0);
		rd(`ADDR_CONTROL, d); check(d, 8'h90, "capture flag");
		rd(`ADDR_RELOAD_LOW, d); check({7'h00, d != 8'h00}, 8'h01, "captured");
		$display("test capture done");
		stop_test();
	end
endmodule : test_timer2_control_and_capture
`default_nettype wire
